// File: hw/epsm_pkg.sv
package epsm_pkg;
	// register byte addresses on the apb bus
	localparam logic [7:0] EPSM_ADDR_PMCTRL = 8'h00;
	localparam logic [7:0] EPSM_ADDR_TEST = 8'h04;
	localparam logic [7:0] EPSM_ADDR_INTSTS = 8'h08;
	localparam logic [7:0] EPSM_ADDR_PHYCTRL = 8'h0c;
	localparam logic [7:0] EPSM_ADDR_CFG = 8'h10;
	// power_mgmt_control_reg fields
	localparam int EPSM_PM_READY = 0;
	localparam int EPSM_PM_WAKE_OUT_EN = 1;
	localparam int EPSM_PM_IND_MODE = 2;
	localparam int EPSM_PM_WAKE_ON_LAN_ENABLE = 3;
	localparam int EPSM_PM_ENERGY_DETECT_ENABLE = 4;
	localparam int EPSM_PM_WAKE_STATUS_FIELD_LO = 5;
	localparam int EPSM_POWER_MODE_FIELD_LO = 7;
	// interrupt_status_reg fields
	localparam int EPSM_INT_WAKE = 0;
	// phy control fields
	localparam int EPSM_PHY_GEN_PD = 0;
	localparam int EPSM_PHY_ED_PD = 1;
	localparam int EPSM_PHY_ED_FLAG = 2;
	localparam int EPSM_PHY_ACTIVE = 3;
	localparam int EPSM_PHY_IN_RESET = 4;
	// encodings
	localparam logic [1:0] EPSM_MODE_NORMAL = 2'h0;
	localparam logic [1:0] EPSM_MODE_WOL = 2'h1;
	localparam logic [1:0] EPSM_MODE_ED = 2'h2;
	localparam logic [1:0] EPSM_WAKE_STATUS_FIELD_NONE = 2'h0;
	localparam logic [1:0] EPSM_WAKE_STATUS_FIELD_ED = 2'h1;
	localparam logic [1:0] EPSM_WAKE_STATUS_FIELD_WOL = 2'h2;
	localparam logic [31:0] EPSM_TEST_PATTERN = 32'h87654321;
	// timing
	localparam int EPSM_CLK_HZ = 10_000_000;
	localparam int EPSM_PULSE_MS = 50;
	localparam int EPSM_READY_MAX_MS = 2;
	localparam int EPSM_PULSE_CYC = EPSM_CLK_HZ / 1000 * EPSM_PULSE_MS;
	localparam int EPSM_READY_CYC = EPSM_CLK_HZ / 1000 * EPSM_READY_MAX_MS / 2;
	localparam int EPSM_PHY_RST_CYC = 16;
	typedef enum logic [1:0] {
		EPSM_ST_NORMAL,
		EPSM_ST_WOL,
		EPSM_ST_ED,
		EPSM_ST_WAKING
	} epsm_state_t;
endpackage : epsm_pkg

// File: hw/epsm_top.sv
`timescale 1ns/1ps
// What this block does
// - sleep: only power control register is readable
// - ready clears on sleep entry until wake
// - writes other than the wake write ignored until a first read
// - test write in sleep wakes, mode to normal
// - mode 01 enters wol sleep, gates mac clocks
// - wol sleep detects frames, status becomes 10b
// - wol and output enable drive wake output
// - wake interrupt status set on any event
// - energy sleep stops all clocks, phy power left to phy control bits
// - energy sleep carrier sets output, status 01b
// - wake interrupt held until cause is cleared
// - host interrupt independent of output enable
// - indication mode selects 50ms pulse or level
// - output drops on status, enable or outenable clear
// - phy general powerdown, reset on release
// - phy energy powerdown, restore and flag on energy
// - registers retained across both sleep states
// - ready set within 2ms after wake write
module epsm_top #(
	parameter int PULSE_CYC = epsm_pkg::EPSM_PULSE_CYC, // wake pulse length
	parameter int READY_CYC = epsm_pkg::EPSM_READY_CYC // wake to ready delay
) (
	input wire logic clk, // 10 mhz clock
	input wire logic rst, // sync reset, active high
	input wire logic psel, // apb select
	input wire logic penable, // apb enable
	input wire logic pwrite, // apb direction
	input wire logic [7:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error
	input wire logic wake_frame_seen, // filter found wake frame
	input wire logic magic_packet_seen, // magic packet found
	input wire logic carrier_valid, // valid line carrier
	input wire logic energy_present_signal, // line energy detected
	output logic wake_out, // external wake event, active high
	output logic host_irq, // host interrupt
	output logic mac_clk_en, // mac and host interface clock gate
	output logic rx_pm_clk_en, // receive power mgmt clock gate
	output logic int_clk_en, // internal clock gate
	output logic phy_powered, // phy analog powered
	output logic phy_reset, // phy self reset pulse
	output logic filter_en // wake frame and magic detection
);
	import epsm_pkg::*;

	initial begin
		if (PULSE_CYC < 1 || READY_CYC < 1 || READY_CYC > EPSM_CLK_HZ / 500)
			$error("epsm_top: bad timing parameter");
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	epsm_state_t state_reg;
	logic ready_reg;
	logic wake_out_en_reg;
	logic ind_mode_reg;
	logic wake_on_lan_enable_reg;
	logic energy_detect_enable_reg;
	logic [1:0] wake_status_field;
	logic [1:0] power_mode_field;
	logic wake_int_reg;
	logic irq_en_reg;
	logic read_seen_reg;
	logic gen_pd_reg;
	logic phy_energy_powerdown_bit;
	logic phy_ed_flag_reg;
	logic phy_rst_reg;
	logic [4:0] phy_rst_cnt_reg;
	logic [31:0] ready_cnt_reg;
	logic [31:0] pulse_cnt_reg;
	logic wake_drive_reg;
	logic energy_prev_reg;

	// ----------------------------------------
	// bus decode
	// ----------------------------------------
	logic acc;
	logic wr;
	logic rd;
	logic rd_setup;
	logic sleeping;
	logic wr_ok;
	logic wake_write;
	logic hit_pm;
	logic hit_test;
	logic hit_int;
	logic hit_phy;
	logic hit_cfg;
	logic mapped;

	assign acc = psel && penable;
	assign sleeping = (state_reg == EPSM_ST_WOL) || (state_reg == EPSM_ST_ED);
	assign hit_pm = paddr == EPSM_ADDR_PMCTRL;
	assign hit_test = paddr == EPSM_ADDR_TEST;
	assign hit_int = paddr == EPSM_ADDR_INTSTS;
	assign hit_phy = paddr == EPSM_ADDR_PHYCTRL;
	assign hit_cfg = paddr == EPSM_ADDR_CFG;
	assign mapped = hit_pm || hit_test || hit_int || hit_phy || hit_cfg;
	assign rd = acc && !pwrite;
	// read data loaded in setup so it stands at the access edge
	assign rd_setup = psel && !penable && !pwrite;
	assign wr = acc && pwrite;
	// wake write decoded without the gated clock domain
	assign wake_write = wr && hit_test && sleeping;
	// writes need a prior read and a ready device
	assign wr_ok = wr && read_seen_reg && ready_reg;
	assign pready = 1'b1;
	// refused: unmapped, or anything but control reads and the wake write while unready
	assign pslverr = acc && (!mapped || (!ready_reg && !(rd && hit_pm) && !wake_write));

	logic wol_hit;
	logic ed_hit;
	logic cause_live;
	assign wol_hit = (state_reg == EPSM_ST_WOL) && (wake_frame_seen || magic_packet_seen);
	// level carrier, so carrier present at entry hits at once
	assign ed_hit = (state_reg == EPSM_ST_ED) && carrier_valid && energy_detect_enable_reg;
	assign cause_live = (wake_status_field != EPSM_WAKE_STATUS_FIELD_NONE)
		&& ((wake_status_field == EPSM_WAKE_STATUS_FIELD_WOL) ? wake_on_lan_enable_reg : energy_detect_enable_reg);

	// ----------------------------------------
	// read data
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			prdata <= 32'h0;
		end else if (rd_setup && mapped && (ready_reg || hit_pm)) begin
			prdata <= 32'h0;
			if (hit_pm) begin
				prdata[EPSM_PM_READY] <= ready_reg;
				prdata[EPSM_PM_WAKE_OUT_EN] <= wake_out_en_reg;
				prdata[EPSM_PM_IND_MODE] <= ind_mode_reg;
				prdata[EPSM_PM_WAKE_ON_LAN_ENABLE] <= wake_on_lan_enable_reg;
				prdata[EPSM_PM_ENERGY_DETECT_ENABLE] <= energy_detect_enable_reg;
				prdata[EPSM_PM_WAKE_STATUS_FIELD_LO +: 2] <= wake_status_field;
				prdata[EPSM_POWER_MODE_FIELD_LO +: 2] <= power_mode_field;
			end
			if (hit_test)
				prdata <= EPSM_TEST_PATTERN;
			if (hit_int)
				prdata[EPSM_INT_WAKE] <= wake_int_reg;
			if (hit_phy) begin
				prdata[EPSM_PHY_GEN_PD] <= gen_pd_reg;
				prdata[EPSM_PHY_ED_PD] <= phy_energy_powerdown_bit;
				prdata[EPSM_PHY_ED_FLAG] <= phy_ed_flag_reg;
				prdata[EPSM_PHY_ACTIVE] <= phy_powered;
				prdata[EPSM_PHY_IN_RESET] <= phy_rst_reg;
			end
			if (hit_cfg)
				prdata[0] <= irq_en_reg;
		end
	end

	always_ff @(posedge clk) begin
		if (rst)
			read_seen_reg <= 1'b0;
		else if (wake_write || (sleeping && !ready_reg))
			read_seen_reg <= 1'b0;
		else if (rd)
			read_seen_reg <= 1'b1;
	end

	// ----------------------------------------
	// power state machine
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			state_reg <= EPSM_ST_NORMAL;
			power_mode_field <= EPSM_MODE_NORMAL;
			ready_reg <= 1'b1;
			ready_cnt_reg <= 32'h0;
		end else begin
			case (state_reg)
				EPSM_ST_NORMAL: begin
					if (wr_ok && hit_pm) begin
						power_mode_field <= pwdata[EPSM_POWER_MODE_FIELD_LO +: 2];
						if (pwdata[EPSM_POWER_MODE_FIELD_LO +: 2] == EPSM_MODE_WOL) begin
							state_reg <= EPSM_ST_WOL;
							ready_reg <= 1'b0;
						end else if (pwdata[EPSM_POWER_MODE_FIELD_LO +: 2] == EPSM_MODE_ED) begin
							state_reg <= EPSM_ST_ED;
							ready_reg <= 1'b0;
						end
					end
				end
				EPSM_ST_WOL, EPSM_ST_ED: begin
					if (wake_write) begin
						state_reg <= EPSM_ST_WAKING;
						power_mode_field <= EPSM_MODE_NORMAL;
						ready_cnt_reg <= 32'h0;
					end
				end
				EPSM_ST_WAKING: begin
					// clocks already running here; ready follows
					if (ready_cnt_reg >= 32'(READY_CYC - 1)) begin
						state_reg <= EPSM_ST_NORMAL;
						ready_reg <= 1'b1;
					end else begin
						ready_cnt_reg <= ready_cnt_reg + 32'h1;
					end
				end
				default: state_reg <= EPSM_ST_NORMAL;
			endcase
		end
	end

	// clock gates; register contents retained, only clocks stop
	assign mac_clk_en = (state_reg == EPSM_ST_NORMAL) || (state_reg == EPSM_ST_WAKING);
	assign rx_pm_clk_en = state_reg != EPSM_ST_ED;
	assign int_clk_en = state_reg != EPSM_ST_ED;
	assign filter_en = state_reg == EPSM_ST_WOL;

	// ----------------------------------------
	// control bits and wake status
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			wake_out_en_reg <= 1'b0;
			ind_mode_reg <= 1'b0;
			wake_on_lan_enable_reg <= 1'b0;
			energy_detect_enable_reg <= 1'b0;
			irq_en_reg <= 1'b0;
		end else if (wr_ok && hit_pm) begin
			wake_out_en_reg <= pwdata[EPSM_PM_WAKE_OUT_EN];
			ind_mode_reg <= pwdata[EPSM_PM_IND_MODE];
			wake_on_lan_enable_reg <= pwdata[EPSM_PM_WAKE_ON_LAN_ENABLE];
			energy_detect_enable_reg <= pwdata[EPSM_PM_ENERGY_DETECT_ENABLE];
		end else if (wr_ok && hit_cfg) begin
			irq_en_reg <= pwdata[0];
		end
	end

	always_ff @(posedge clk) begin
		if (rst)
			wake_status_field <= EPSM_WAKE_STATUS_FIELD_NONE;
		else if (wol_hit)
			wake_status_field <= EPSM_WAKE_STATUS_FIELD_WOL;
		else if (ed_hit)
			wake_status_field <= EPSM_WAKE_STATUS_FIELD_ED;
		else if (wr_ok && hit_pm && pwdata[EPSM_PM_WAKE_STATUS_FIELD_LO +: 2] == EPSM_WAKE_STATUS_FIELD_NONE)
			wake_status_field <= EPSM_WAKE_STATUS_FIELD_NONE;
	end

	// write one clears only once the cause is gone; set wins
	always_ff @(posedge clk) begin
		if (rst)
			wake_int_reg <= 1'b0;
		else if (wol_hit || ed_hit || cause_live)
			wake_int_reg <= 1'b1;
		else if (wr_ok && hit_int && pwdata[EPSM_INT_WAKE])
			wake_int_reg <= 1'b0;
	end
	assign host_irq = wake_int_reg && irq_en_reg;

	// ----------------------------------------
	// wake output
	// ----------------------------------------
	logic wake_event;
	assign wake_event = (wol_hit && wake_on_lan_enable_reg) || ed_hit;
	always_ff @(posedge clk) begin
		if (rst) begin
			wake_drive_reg <= 1'b0;
			pulse_cnt_reg <= 32'h0;
		end else if (!wake_out_en_reg || !cause_live) begin
			wake_drive_reg <= wake_event && wake_out_en_reg;
			pulse_cnt_reg <= 32'h0;
		end else if (wake_event && !wake_drive_reg && pulse_cnt_reg == 32'h0) begin
			wake_drive_reg <= 1'b1;
		end else if (wake_drive_reg && ind_mode_reg) begin
			if (pulse_cnt_reg >= 32'(PULSE_CYC - 1))
				wake_drive_reg <= 1'b0;
			else
				pulse_cnt_reg <= pulse_cnt_reg + 32'h1;
		end
	end
	assign wake_out = wake_drive_reg && wake_out_en_reg;

	// ----------------------------------------
	// phy power-down modes
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			gen_pd_reg <= 1'b0;
			phy_energy_powerdown_bit <= 1'b0;
			phy_ed_flag_reg <= 1'b0;
			phy_rst_reg <= 1'b0;
			phy_rst_cnt_reg <= 5'h0;
			energy_prev_reg <= 1'b0;
		end else begin
			energy_prev_reg <= energy_present_signal;
			if (wr_ok && hit_phy) begin
				gen_pd_reg <= pwdata[EPSM_PHY_GEN_PD];
				phy_energy_powerdown_bit <= pwdata[EPSM_PHY_ED_PD];
				if (gen_pd_reg && !pwdata[EPSM_PHY_GEN_PD]) begin
					phy_rst_reg <= 1'b1;
					phy_rst_cnt_reg <= 5'(EPSM_PHY_RST_CYC);
				end
			end else if (phy_rst_reg) begin
				if (phy_rst_cnt_reg == 5'h1)
					phy_rst_reg <= 1'b0;
				phy_rst_cnt_reg <= phy_rst_cnt_reg - 5'h1;
			end
			// energy rise flags; set beats a read clear
			if (phy_energy_powerdown_bit && energy_present_signal && !energy_prev_reg)
				phy_ed_flag_reg <= 1'b1;
			else if (ready_reg && rd && hit_phy && prdata[EPSM_PHY_ED_FLAG]) // only a flag seen
				phy_ed_flag_reg <= 1'b0;
		end
	end
	// phy powered unless in general or energy power-down with no energy
	assign phy_powered = !gen_pd_reg && !(phy_energy_powerdown_bit && !energy_present_signal);
	assign phy_reset = phy_rst_reg;
endmodule : epsm_top

// File: verification/epsm_assertions.sv
`timescale 1ns/1ps
module epsm_checker import epsm_pkg::*; (
	input wire logic clk, // clock
	input wire logic rst, // reset
	input wire logic psel, // select
	input wire logic penable, // enable
	input wire logic pwrite, // direction
	input wire logic [7:0] paddr, // address
	input wire logic [31:0] pwdata, // write data
	input wire logic pslverr, // error
	input wire logic wake_out, // wake event
	input wire logic mac_clk_en, // mac gate
	input wire logic rx_pm_clk_en, // rx gate
	input wire logic int_clk_en, // internal gate
	input wire logic filter_en // detection on
);
	logic rd_ok;
	wire acc = psel && penable;
	wire wr0 = acc && pwrite && paddr == EPSM_ADDR_PMCTRL && !pslverr;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// read seen since reset or since last sleep
	always_ff @(posedge clk) begin
		if (rst || !mac_clk_en) rd_ok <= 1'h0;
		else if (acc && !pwrite && !pslverr) rd_ok <= 1'h1;
	end
	property p_ed_gate; !int_clk_en |-> !mac_clk_en && !rx_pm_clk_en; endproperty
	a_ed_gate: assert property (p_ed_gate) else $error("gating in ed sleep");
	property p_wol_gate; !mac_clk_en && int_clk_en |-> rx_pm_clk_en && filter_en; endproperty
	a_wol_gate: assert property (p_wol_gate) else $error("gating in wol sleep");
	property p_rd_lock; acc && !mac_clk_en && !pwrite && paddr != EPSM_ADDR_PMCTRL |-> pslverr;
	endproperty
	a_rd_lock: assert property (p_rd_lock) else $error("read allowed in sleep");
	property p_wr_lock; acc && !mac_clk_en && pwrite && paddr != EPSM_ADDR_TEST |-> pslverr;
	endproperty
	a_wr_lock: assert property (p_wr_lock) else $error("write allowed in sleep");
	property p_wake; acc && pwrite && paddr == EPSM_ADDR_TEST && !mac_clk_en |-> ##[1:3] mac_clk_en;
	endproperty
	a_wake: assert property (p_wake) else $error("no wake on test write");
	property p_go_wol; wr0 && rd_ok && mac_clk_en && pwdata[EPSM_POWER_MODE_FIELD_LO +: 2] == EPSM_MODE_WOL
		|=> !mac_clk_en && int_clk_en; endproperty
	a_go_wol: assert property (p_go_wol) else $error("no wol sleep entry");
	property p_go_ed; wr0 && rd_ok && mac_clk_en && pwdata[EPSM_POWER_MODE_FIELD_LO +: 2] == EPSM_MODE_ED
		|=> !int_clk_en;
	endproperty
	a_go_ed: assert property (p_go_ed) else $error("no ed sleep entry");
	property p_early; wr0 && !rd_ok && mac_clk_en |=> mac_clk_en; endproperty
	a_early: assert property (p_early) else $error("write before read took effect");
	property p_drop; wr0 && rd_ok && !pwdata[EPSM_PM_WAKE_OUT_EN] |=> !wake_out; endproperty
	a_drop: assert property (p_drop) else $error("wake out kept");
	c_wol: cover property (!mac_clk_en && int_clk_en);
	c_ed: cover property (!int_clk_en);
	c_pulse: cover property ($rose(wake_out));
endmodule : epsm_checker
bind epsm_top epsm_checker chk_u (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr), .wake_out(wake_out),
	.mac_clk_en(mac_clk_en), .rx_pm_clk_en(rx_pm_clk_en), .int_clk_en(int_clk_en),
	.filter_en(filter_en));

// File: verification/epsm_line_model.sv
`timescale 1ns/1ps
module epsm_line_model (
	input wire logic clk, // clock
	input wire logic [3:0] req, // frame, magic, carrier, energy
	input wire logic slow, // answer a cycle later
	output logic wake_frame_seen, // wake frame found
	output logic magic_packet_seen, // magic packet found
	output logic carrier_valid, // carrier on line
	output logic energy_present_signal // energy on line
);
	logic [3:0] dly = 4'h0;
	logic [3:0] cur = 4'h0;
	always @(posedge clk) begin
		dly <= req;
		cur <= slow ? dly : req;
	end
	assign {wake_frame_seen, magic_packet_seen, carrier_valid, energy_present_signal} = cur;
endmodule : epsm_line_model

// File: verification/ethernet_power_state_manager_tb.sv
`timescale 1ns/1ps
module ethernet_power_state_manager_tb;
	import epsm_pkg::*;
	localparam int PC = 20;
	localparam int RC = 5;
	typedef struct {logic [31:0] m; logic [31:0] e; logic er;} epsm_note_t;
	logic clk = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, slow = 1'h0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, wfs, mps, cv, eps;
	logic wake_out, host_irq, mac_clk_en, rx_pm_clk_en, int_clk_en, phy_powered, phy_reset;
	logic filter_en;
	logic [3:0] line_req = 4'h0;
	epsm_note_t q[$];
	epsm_note_t nt;
	int num_errors = 0, total_checks = 0, n, hi, rc;
	epsm_top #(.PULSE_CYC(PC), .READY_CYC(RC)) dut_u (.clk(clk), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .wake_frame_seen(wfs), .magic_packet_seen(mps),
		.carrier_valid(cv), .energy_present_signal(eps), .wake_out(wake_out),
		.host_irq(host_irq), .mac_clk_en(mac_clk_en), .rx_pm_clk_en(rx_pm_clk_en),
		.int_clk_en(int_clk_en), .phy_powered(phy_powered), .phy_reset(phy_reset),
		.filter_en(filter_en));
	epsm_line_model line_u (.clk(clk), .req(line_req), .slow(slow), .wake_frame_seen(wfs),
		.magic_packet_seen(mps), .carrier_valid(cv), .energy_present_signal(eps));
	initial begin
		forever #50 clk = ~clk;
	end
	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task results;
		$display("checks %0d mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : results
	// -----------------------------------------
	// apb master, notes go to the monitor queue
	// -----------------------------------------
	task acc(input logic w, input logic [7:0] a, input logic [31:0] d, m, e, input logic er);
		q.push_back('{m, e, er});
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		@(posedge clk);
		while (pready !== 1'h1) @(posedge clk);
		rd = prdata;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge clk);
	endtask : acc
	task wr(input logic [7:0] a, input logic [31:0] d, input logic er);
		acc(1'h1, a, d, 32'h0, 32'h0, er);
	endtask : wr
	task rdc(input logic [7:0] a, input logic [31:0] m, e, input logic er);
		acc(1'h0, a, 32'h0, m, e, er);
	endtask : rdc
	task wake_up;
		wr(EPSM_ADDR_TEST, $urandom, 1'h0);
		n = 0;
		rd = 32'h0;
		while (rd[EPSM_PM_READY] !== 1'h1 && n < 50) begin
			rdc(EPSM_ADDR_PMCTRL, 32'h0, 32'h0, 1'h0);
			n++;
		end
		chk("ready polls", {31'h0, n <= RC}, 32'h1);
	endtask : wake_up
	// compare at the access edge, where the master takes its data
	always @(posedge clk) begin
		if (psel === 1'h1 && penable === 1'h1 && pready === 1'h1) begin
			nt = q.pop_front();
			chk("rdata", prdata & nt.m, nt.e);
			chk("slverr", {31'h0, pslverr}, {31'h0, nt.er});
		end
		if (wake_out === 1'h1) hi++;
		if (phy_reset === 1'h1) rc++;
	end
	initial begin
		repeat (3000) @(posedge clk);
		num_errors++;
		results();
	end
	initial begin
		void'($urandom(33011));
		repeat (8) @(posedge clk);
		rst <= 1'h0;
		@(posedge clk);
		wr(EPSM_ADDR_CFG, 32'h1, 1'h0);
		wr(EPSM_ADDR_PMCTRL, 32'h80, 1'h0);
		rdc(EPSM_ADDR_PMCTRL, 32'h1ff, 32'h1, 1'h0);
		rdc(EPSM_ADDR_CFG, 32'h1, 32'h0, 1'h0);
		wr(EPSM_ADDR_CFG, 32'h1, 1'h0);
		rdc(EPSM_ADDR_CFG, 32'h1, 32'h1, 1'h0);
		rdc(EPSM_ADDR_TEST, 32'hffffffff, EPSM_TEST_PATTERN, 1'h0);
		rdc(8'h14, 32'h0, 32'h0, 1'h1);
		$display("test access done");
		wr(EPSM_ADDR_PMCTRL, 32'h0a, 1'h0);
		wr(EPSM_ADDR_PMCTRL, 32'h8a, 1'h0);
		rdc(EPSM_ADDR_PMCTRL, 32'h181, 32'h80, 1'h0);
		rdc(EPSM_ADDR_CFG, 32'h0, 32'h0, 1'h1);
		wr(EPSM_ADDR_CFG, 32'h0, 1'h1);
		chk("gates", {29'h0, mac_clk_en, rx_pm_clk_en, int_clk_en}, 32'h3);
		slow <= 1'($urandom_range(1, 0));
		line_req <= $urandom_range(1, 0) ? 4'h8 : 4'h4;
		repeat (4) @(posedge clk);
		line_req <= 4'h0;
		@(posedge clk);
		chk("wake out", {31'h0, wake_out}, 32'h1);
		chk("host irq", {31'h0, host_irq}, 32'h1);
		rdc(EPSM_ADDR_PMCTRL, 32'h60, 32'h40, 1'h0);
		wake_up();
		rdc(EPSM_ADDR_PMCTRL, 32'h1ff, 32'h4b, 1'h0);
		rdc(EPSM_ADDR_INTSTS, 32'h1, 32'h1, 1'h0);
		wr(EPSM_ADDR_INTSTS, 32'h1, 1'h0);
		rdc(EPSM_ADDR_INTSTS, 32'h1, 32'h1, 1'h0);
		wr(EPSM_ADDR_PMCTRL, 32'h0a, 1'h0);
		@(posedge clk);
		chk("wake out", {31'h0, wake_out}, 32'h0);
		wr(EPSM_ADDR_INTSTS, 32'h1, 1'h0);
		rdc(EPSM_ADDR_INTSTS, 32'h1, 32'h0, 1'h0);
		$display("test wol done");
		line_req <= 4'h3;
		wr(EPSM_ADDR_PHYCTRL, 32'h2, 1'h0);
		wr(EPSM_ADDR_PMCTRL, 32'h16, 1'h0);
		hi = 0;
		wr(EPSM_ADDR_PMCTRL, 32'h116, 1'h0);
		chk("gates", {29'h0, mac_clk_en, rx_pm_clk_en, int_clk_en}, 32'h0);
		repeat (3 * PC) @(posedge clk);
		chk("pulse len", hi, PC);
		rdc(EPSM_ADDR_PMCTRL, 32'h60, 32'h20, 1'h0);
		wake_up();
		wr(EPSM_ADDR_PHYCTRL, 32'h0, 1'h0);
		wr(EPSM_ADDR_PMCTRL, 32'h14, 1'h0);
		line_req <= 4'h0;
		$display("test ed done");
		wr(EPSM_ADDR_PHYCTRL, 32'h1, 1'h0);
		chk("phy powered", {31'h0, phy_powered}, 32'h0);
		rc = 0;
		wr(EPSM_ADDR_PHYCTRL, 32'h0, 1'h0);
		repeat (40) @(posedge clk);
		chk("phy reset", rc, EPSM_PHY_RST_CYC);
		chk("phy powered", {31'h0, phy_powered}, 32'h1);
		$display("test phy done");
		results();
	end
endmodule : ethernet_power_state_manager_tb
